//--- fsp_ctrl.sv
// Purpose: drives the flash self-program sequencer like the core would
// Assumes: device pins synchronous to sys_clk, one command at a time
// Notes: software orders come in over a plain strobe port
`timescale 1ns/1ns
module fsp_ctrl #(
    parameter int WORD_BITS = 7,
    parameter int TIMEOUT_CYCLES = fsp_pkg::PROG_TIMEOUT_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [fsp_pkg::ADDR_W-1:0] addr,
    input wire logic [fsp_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [fsp_pkg::DATA_W-1:0] rdata,
    output fsp_pkg::fsp_dev_out_t dev_o,
    input wire fsp_pkg::fsp_dev_in_t dev_i
);
    localparam logic [7:0] LAST_IDX = 8'((1 << WORD_BITS) - 1);
    localparam logic [fsp_pkg::DONE_CNT_W-1:0] TMO = fsp_pkg::DONE_CNT_W'(TIMEOUT_CYCLES);

    typedef struct packed {
        fsp_pkg::fsp_state_t st;
        logic [2:0] op;
        logic [15:0] page;
        logic [7:0] arg;
        logic [7:0] idx;
        logic [7:0] mem_addr;
        logic [fsp_pkg::DONE_CNT_W-1:0] tmo;
        logic [7:0] result;
        logic busy;
        logic done;
        logic err;
        logic lost;
        logic loaded;
        logic [fsp_pkg::DATA_W-1:0] rdata;
        fsp_pkg::fsp_dev_out_t dev;
    } fsp_ctrl_state_t;

    fsp_ctrl_state_t s;
    fsp_ctrl_state_t next_s;
    logic [15:0] mem_word;
    logic mem_wr;

    function automatic logic [7:0] fsp_pattern(input logic [2:0] op);
        case (op)
            fsp_pkg::OP_FILL: fsp_pattern = fsp_pkg::CTL_FILL;
            fsp_pkg::OP_ERASE: fsp_pattern = fsp_pkg::CTL_ERASE;
            fsp_pkg::OP_WRITE: fsp_pattern = fsp_pkg::CTL_WRITE;
            fsp_pkg::OP_REENABLE: fsp_pattern = fsp_pkg::CTL_REENABLE;
            default: fsp_pattern = fsp_pkg::CTL_LOCK;
        endcase
    endfunction

    function automatic logic fsp_op_valid(input logic [2:0] op);
        fsp_op_valid = (op >= fsp_pkg::OP_FILL) && (op <= fsp_pkg::OP_READ);
    endfunction

    function automatic logic [15:0] fsp_page_ptr(input logic [15:0] page);
        fsp_page_ptr = 16'(page << (WORD_BITS + 1));
    endfunction

    assign mem_wr = wr && (addr == fsp_pkg::REG_MEM_DATA) && !s.busy;

    fsp_page_mem #(
        .WIDTH(16),
        .AW(WORD_BITS)
    ) u_mem (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(mem_wr),
        .wr_addr(s.mem_addr[WORD_BITS-1:0]),
        .wr_data(wdata),
        .rd_addr(s.idx[WORD_BITS-1:0]),
        .rd_data(mem_word)
    );

    always_comb begin
        next_s = s;
        next_s.dev.ctl_wr = 1'b0;
        next_s.dev.store = 1'b0;
        next_s.dev.load = 1'b0;
        next_s.rdata = '0;

        // software port; command and page are refused while an operation runs
        if (wr) begin
            case (addr)
                fsp_pkg::REG_PAGE: if (!s.busy) next_s.page = wdata;
                fsp_pkg::REG_ARG: if (!s.busy) next_s.arg = wdata[7:0];
                fsp_pkg::REG_MEM_ADDR: if (!s.busy) next_s.mem_addr = wdata[7:0];
                fsp_pkg::REG_MEM_DATA: if (!s.busy) next_s.mem_addr = s.mem_addr + 8'h01;
                default: ;
            endcase
        end
        if (rd) begin
            case (addr)
                fsp_pkg::REG_PAGE: next_s.rdata = s.page;
                fsp_pkg::REG_ARG: next_s.rdata = {8'h00, s.arg};
                fsp_pkg::REG_STATUS: next_s.rdata = {10'h000, s.loaded,
                    dev_i.ctl_rdata[fsp_pkg::BIT_SECTION_BUSY], s.lost, s.err, s.done, s.busy};
                fsp_pkg::REG_RESULT: next_s.rdata = {8'h00, s.result};
                fsp_pkg::REG_MEM_ADDR: next_s.rdata = {8'h00, s.mem_addr};
                default: next_s.rdata = '0;
            endcase
        end

        case (s.st)
            fsp_pkg::ST_IDLE: begin
                next_s.busy = 1'b0;
                if (wr && addr == fsp_pkg::REG_CMD && fsp_op_valid(wdata[2:0])) begin
                    next_s.op = wdata[2:0];
                    next_s.idx = '0;
                    next_s.done = 1'b0;
                    next_s.err = 1'b0;
                    if (wdata[2:0] == fsp_pkg::OP_FILL) begin
                        next_s.lost = 1'b0;
                    end
                    next_s.busy = 1'b1;
                    next_s.st = fsp_pkg::ST_WAIT_EE;
                end
            end
            fsp_pkg::ST_WAIT_EE: begin
                // control register is only touched with the eeprom idle
                if (!dev_i.eeprom_write_busy) begin
                    next_s.st = fsp_pkg::ST_WAIT_FREE;
                end
            end
            fsp_pkg::ST_WAIT_FREE: begin
                // a previous operation still owns the enable bit
                if (dev_i.eeprom_write_busy) begin
                    next_s.st = fsp_pkg::ST_WAIT_EE;
                end else if (!dev_i.cpu_halt && !dev_i.ctl_rdata[fsp_pkg::BIT_OP_ENABLE]) begin
                    next_s.st = fsp_pkg::ST_SET_CTL;
                end
            end
            fsp_pkg::ST_SET_CTL: begin
                next_s.dev.ctl_wr = 1'b1;
                next_s.dev.word_data_pair = '0;
                next_s.dev.ctl_wdata = fsp_pattern(s.op);
                next_s.st = fsp_pkg::ST_STORE;
                case (s.op)
                    fsp_pkg::OP_FILL: begin
                        next_s.dev.ptr = fsp_page_ptr(s.page) | 16'({s.idx, 1'b0});
                        next_s.dev.word_data_pair = mem_word;
                    end
                    fsp_pkg::OP_ERASE, fsp_pkg::OP_WRITE: begin
                        next_s.dev.ptr = fsp_page_ptr(s.page);
                    end
                    fsp_pkg::OP_LOCK: begin
                        next_s.dev.ptr = fsp_pkg::PTR_LOCK;
                        next_s.dev.word_data_pair = {8'h00, fsp_pkg::LOCK_PAD, s.arg[3:0],
                            fsp_pkg::LOCK_PAD};
                    end
                    fsp_pkg::OP_READ: begin
                        next_s.dev.ptr = {14'h0000, s.arg[1:0]};
                        next_s.st = fsp_pkg::ST_LOAD;
                    end
                    default: next_s.dev.ptr = '0;
                endcase
                // an eeprom write starting now still beats the control write; pins keep their values
                if (dev_i.eeprom_write_busy) begin
                    next_s.dev = s.dev;
                    next_s.dev.ctl_wr = 1'b0;
                    next_s.st = fsp_pkg::ST_WAIT_EE;
                end
            end
            fsp_pkg::ST_STORE: begin
                // store follows the control write by one cycle, well inside four
                next_s.dev.store = 1'b1;
                next_s.tmo = '0;
                next_s.st = fsp_pkg::ST_WAIT_DONE;
            end
            fsp_pkg::ST_LOAD: begin
                // load follows the control write by one cycle, inside three
                next_s.dev.load = 1'b1;
                next_s.tmo = '0;
                next_s.st = fsp_pkg::ST_WAIT_RD;
            end
            fsp_pkg::ST_WAIT_RD: begin
                next_s.tmo = s.tmo + fsp_pkg::DONE_CNT_W'(1);
                if (dev_i.load_valid) begin
                    next_s.result = dev_i.load_data;
                    next_s.done = 1'b1;
                    next_s.st = fsp_pkg::ST_IDLE;
                end else if (s.tmo >= TMO) begin
                    next_s.err = 1'b1;
                    next_s.st = fsp_pkg::ST_IDLE;
                end
            end
            fsp_pkg::ST_WAIT_DONE: begin
                // a halted core does nothing, but the bound still runs
                next_s.tmo = s.tmo + fsp_pkg::DONE_CNT_W'(1);
                if (!dev_i.cpu_halt && !dev_i.ctl_rdata[fsp_pkg::BIT_OP_ENABLE]) begin
                    if (s.op == fsp_pkg::OP_FILL) begin
                        next_s.loaded = 1'b1;
                    end
                    if (s.op == fsp_pkg::OP_WRITE || s.op == fsp_pkg::OP_REENABLE) begin
                        next_s.loaded = 1'b0;
                    end
                    if (s.op == fsp_pkg::OP_FILL && s.idx != LAST_IDX) begin
                        next_s.idx = s.idx + 8'h01;
                        next_s.st = fsp_pkg::ST_WAIT_EE;
                    end else begin
                        next_s.done = 1'b1;
                        next_s.st = fsp_pkg::ST_IDLE;
                    end
                end else if (s.tmo >= TMO) begin
                    next_s.err = 1'b1;
                    next_s.st = fsp_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.st = fsp_pkg::ST_IDLE;
            end
        endcase

        // an eeprom write with words already in the buffer wipes them; placed last so
        // the loss wins over a fill finishing or a new fill clearing the flag
        if (s.loaded && dev_i.eeprom_write_busy) begin
            next_s.loaded = 1'b0;
            next_s.lost = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{st: fsp_pkg::ST_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign dev_o = s.dev;
endmodule

//--- fsp_pkg.sv
// Purpose: shared constants and types of the flash self-program controller
// Assumes: 10 MHz sys_clk, 16-bit address pointer, byte-wide control register
// Notes: the device pins travel as two packed structs
package fsp_pkg;
    localparam int CLK_MHZ = 10;
    localparam int PROG_TIME_MAX_US = 4500;
    localparam int PROG_TIMEOUT_CYC = PROG_TIME_MAX_US * CLK_MHZ;
    localparam int DONE_CNT_W = 16;

    // control byte patterns, the don't-care top bit written as zero
    localparam logic [7:0] CTL_FILL = 8'h01;
    localparam logic [7:0] CTL_ERASE = 8'h03;
    localparam logic [7:0] CTL_WRITE = 8'h05;
    localparam logic [7:0] CTL_LOCK = 8'h09;
    localparam logic [7:0] CTL_REENABLE = 8'h11;
    localparam int BIT_OP_ENABLE = 0;
    localparam int BIT_SECTION_BUSY = 6;

    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [1:0] LOCK_PAD = 2'h3;

    // software registers
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_PAGE = 4'h1;
    localparam logic [3:0] REG_ARG = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RESULT = 4'h4;
    localparam logic [3:0] REG_MEM_ADDR = 4'h5;
    localparam logic [3:0] REG_MEM_DATA = 4'h6;

    localparam logic [2:0] OP_FILL = 3'h1;
    localparam logic [2:0] OP_ERASE = 3'h2;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] OP_REENABLE = 3'h4;
    localparam logic [2:0] OP_LOCK = 3'h5;
    localparam logic [2:0] OP_READ = 3'h6;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_WAIT_EE = 8'h02,
        ST_WAIT_FREE = 8'h04,
        ST_SET_CTL = 8'h08,
        ST_STORE = 8'h10,
        ST_LOAD = 8'h20,
        ST_WAIT_RD = 8'h40,
        ST_WAIT_DONE = 8'h80
    } fsp_state_t;

    typedef struct packed {
        logic ctl_wr;
        logic [7:0] ctl_wdata;
        logic store;
        logic load;
        logic [15:0] ptr;
        logic [15:0] word_data_pair;
    } fsp_dev_out_t;

    typedef struct packed {
        logic [7:0] ctl_rdata;
        logic [7:0] load_data;
        logic load_valid;
        logic eeprom_write_busy;
        logic cpu_halt;
    } fsp_dev_in_t;
endpackage

//--- fsp_page_mem.sv
// Purpose: word store holding one page image before it is loaded into the device
// Assumes: one write port, one read port, read data registered
// Notes: array itself is not reset, only the read register
`timescale 1ns/1ns
module fsp_page_mem #(
    parameter int WIDTH = 16,
    parameter int AW = 7
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

//--- fsp_ctrl_monitor.sv
// Purpose: port checks of the flash self-program controller
// Assumes: sees only the controller ports
// Notes: bound at the foot of this file
`timescale 1ns/1ns
module fsp_ctrl_monitor #(
    parameter int WORD_BITS = 7
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [fsp_pkg::ADDR_W-1:0] addr,
    input wire logic [fsp_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [fsp_pkg::DATA_W-1:0] rdata,
    input wire fsp_pkg::fsp_dev_out_t dev_o,
    input wire fsp_pkg::fsp_dev_in_t dev_i
);
    localparam logic [15:0] LOW_MASK = (16'h0002 << WORD_BITS) - 16'h0001;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_ctl_then_instr: assert property (dev_o.ctl_wr |=> dev_o.store || dev_o.load)
        else $error("no instruction one cycle after control write");
    a_instr_after_ctl: assert property (dev_o.store || dev_o.load |-> $past(dev_o.ctl_wr))
        else $error("instruction without control write");
    a_eeprom_blocks: assert property ($past(dev_i.eeprom_write_busy) |-> !dev_o.ctl_wr)
        else $error("control write during eeprom write");
    a_enable_blocks: assert property (dev_i.ctl_rdata[0] |-> !dev_o.ctl_wr)
        else $error("control write while operation armed");
    a_ctl_defined: assert property (dev_o.ctl_wr |-> dev_o.ctl_wdata inside {8'h01, 8'h03, 8'h05, 8'h09, 8'h11})
        else $error("undefined control pattern");
    a_load_pointer: assert property (dev_o.load |-> dev_o.ctl_wdata == 8'h09 && dev_o.ptr[15:2] == 14'h0)
        else $error("load without lock pattern or pointer");
    a_lock_padding: assert property (dev_o.store && dev_o.ctl_wdata == 8'h09 |->
        dev_o.word_data_pair[7:6] == 2'h3 && dev_o.word_data_pair[1:0] == 2'h3 && dev_o.ptr == 16'h0001)
        else $error("lock data padding or pointer wrong");
    a_write_low_zero: assert property (dev_o.ctl_wr && dev_o.ctl_wdata == 8'h05 |-> (dev_o.ptr & LOW_MASK) == 16'h0)
        else $error("page write pointer low bits set");
    a_pointer_held: assert property (!dev_o.ctl_wr |-> $stable(dev_o.ptr))
        else $error("pointer moved without control write");
    c_erase: cover property (dev_o.ctl_wr && dev_o.ctl_wdata == 8'h03);
    c_load: cover property (dev_i.load_valid);
    c_lock: cover property (dev_o.store && dev_o.ctl_wdata == 8'h09);
endmodule
bind fsp_ctrl fsp_ctrl_monitor #(.WORD_BITS(WORD_BITS)) u_fsp_ctrl_monitor (.sys_clk(sys_clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dev_o(dev_o), .dev_i(dev_i));

//--- fsp_dev_model.sv
// Purpose: behavioural self-program sequencer facing the controller
// Assumes: one command at a time, durations shortened to DUR cycles
// Notes: hang stalls an operation so the caller's timeout can be seen
`timescale 1ns/1ns
module fsp_dev_model #(
    parameter int WB = 2,
    parameter int DUR = 20,
    parameter logic [7:0] FUSE_LO = 8'h62,
    parameter logic [7:0] FUSE_HI = 8'h99,
    parameter logic [7:0] FUSE_EXT = 8'hf3
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire fsp_pkg::fsp_dev_out_t dev_o,
    input wire logic ee_busy,
    input wire logic hang,
    output fsp_pkg::fsp_dev_in_t dev_i
);
    logic [7:0] ctl, lock_bits, rbyte;
    logic [15:0] page_buf [0:2**WB-1];
    logic [15:0] op_ptr;
    logic sec_busy, vld;
    int win, cnt;
    assign dev_i = '{{ctl[7], sec_busy, ctl[5:0]}, rbyte, vld, ee_busy, cnt > 0 && op_ptr[15]};
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl <= 8'h00;
            lock_bits <= 8'hff;
            {sec_busy, vld, rbyte, op_ptr, win, cnt} <= '0;
            foreach (page_buf[i]) page_buf[i] <= 16'h0000;
        end else begin
            vld <= 1'b0;
            win <= (win > 0) ? win - 1 : 0;
            if (cnt > 0 && !hang) begin
                cnt <= cnt - 1;
                if (cnt == 1) ctl <= 8'h00;
            end else if (win == 1 && cnt == 0) ctl <= 8'h00;
            if (ee_busy) foreach (page_buf[i]) page_buf[i] <= 16'h0000;
            if (dev_o.ctl_wr && !ee_busy && cnt == 0 && dev_o.ctl_wdata[4:0] inside {1, 3, 5, 9, 17}) begin
                ctl <= dev_o.ctl_wdata;
                win <= 4;
            end
            if (dev_o.load && win > 1 && ctl[4:0] == 5'h09) begin
                vld <= 1'b1;
                case (dev_o.ptr[1:0])
                    2'h0: rbyte <= FUSE_LO;
                    2'h1: rbyte <= lock_bits;
                    2'h2: rbyte <= FUSE_EXT;
                    default: rbyte <= FUSE_HI;
                endcase
                ctl <= 8'h00;
            end
            if (dev_o.store && win > 0 && ctl[0]) begin
                win <= 0;
                case (ctl[4:0])
                    5'h01: begin
                        page_buf[dev_o.ptr[WB:1]] <= dev_o.word_data_pair;
                        ctl <= 8'h00;
                    end
                    5'h03, 5'h05: begin
                        op_ptr <= dev_o.ptr & ~((16'h0002 << WB) - 16'h0001);
                        cnt <= DUR;
                        sec_busy <= 1'b1;
                        if (ctl[2]) foreach (page_buf[i]) page_buf[i] <= 16'h0000;
                    end
                    5'h09: begin
                        lock_bits[5:2] <= lock_bits[5:2] & dev_o.word_data_pair[5:2];
                        cnt <= DUR;
                    end
                    default: begin
                        sec_busy <= 1'b0;
                        foreach (page_buf[i]) page_buf[i] <= 16'h0000;
                        ctl <= 8'h00;
                    end
                endcase
            end
        end
    end
endmodule

//--- flash_self_program_sequencer_bench.sv
// Purpose: self-checking bench of the flash self-program controller
// Assumes: four-word pages and a 50-cycle timeout
// Notes: expected values come from the queue and fuse table below
`timescale 1ns/1ns
module flash_self_program_sequencer_bench;
    localparam logic [7:0] F_LO = 8'h62;
    localparam logic [7:0] F_HI = 8'h99;
    localparam logic [7:0] F_EXT = 8'hf3;
    logic sys_clk, arst_n, wr, rd, ee_busy, hang;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, s, pg;
    fsp_pkg::fsp_dev_out_t dev_o;
    fsp_pkg::fsp_dev_in_t dev_i;
    logic [15:0] exp_q [$];
    logic [7:0] exp_rd [0:3];
    logic [3:0] arg;
    int n_fail = 0, cmp_count = 0, cyc = 0, seed = 67;
    fsp_ctrl #(.WORD_BITS(2), .TIMEOUT_CYCLES(50)) u_fsp_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dev_o(dev_o), .dev_i(dev_i));
    fsp_dev_model #(.FUSE_LO(F_LO), .FUSE_HI(F_HI), .FUSE_EXT(F_EXT)) u_fsp_dev_model (.sys_clk(sys_clk),
        .arst_n(arst_n), .dev_o(dev_o), .ee_busy(ee_busy), .hang(hang), .dev_i(dev_i));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        // read data stand only in the cycle after the strobe, so take them mid-cycle
        @(negedge sys_clk);
        d = rdata;
        @(posedge sys_clk);
    endtask
    task automatic wait_idle();
        s = 16'h0001;
        for (int i = 0; i < 60 && s[0] !== 1'b0; i++) rd_reg(fsp_pkg::REG_STATUS, s);
    endtask
    task automatic run_op(logic [2:0] op);
        wr_reg(fsp_pkg::REG_CMD, {13'h0, op});
        wait_idle();
    endtask
    initial begin
        {wr, rd, ee_busy, hang, addr, wdata} = '0;
        arst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_reg(fsp_pkg::REG_STATUS, s);
        check("status", 16'h0000, s);
        check("buffer", 16'h0000, u_fsp_dev_model.page_buf[0]);
        arg = 4'($random(seed));
        wr_reg(fsp_pkg::REG_ARG, {12'h0, arg});
        run_op(fsp_pkg::OP_LOCK);
        exp_rd = '{F_LO, {2'h3, arg, 2'h3}, F_EXT, F_HI};
        for (int i = 0; i < 4; i++) begin
            wr_reg(fsp_pkg::REG_ARG, 16'(i));
            run_op(fsp_pkg::OP_READ);
            rd_reg(fsp_pkg::REG_RESULT, s);
            check("result", {8'h0, exp_rd[i]}, s);
        end
        pg = 16'($random(seed)) & 16'h0fff;
        wr_reg(fsp_pkg::REG_PAGE, pg);
        rd_reg(fsp_pkg::REG_PAGE, s);
        check("page", pg, s);
        run_op(fsp_pkg::OP_ERASE);
        check("erase page", pg << 3, u_fsp_dev_model.op_ptr);
        rd_reg(fsp_pkg::REG_STATUS, s);
        check("section busy", 16'h1, {15'h0, s[4]});
        wr_reg(fsp_pkg::REG_MEM_ADDR, 16'h0);
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back(16'($random(seed)));
            wr_reg(fsp_pkg::REG_MEM_DATA, exp_q[i]);
        end
        run_op(fsp_pkg::OP_FILL);
        for (int i = 0; i < 4; i++) check("buffer word", exp_q[i], u_fsp_dev_model.page_buf[i]);
        run_op(fsp_pkg::OP_WRITE);
        check("write page", pg << 3, u_fsp_dev_model.op_ptr);
        check("buffer cleared", 16'h0, u_fsp_dev_model.page_buf[3]);
        run_op(fsp_pkg::OP_REENABLE);
        rd_reg(fsp_pkg::REG_STATUS, s);
        check("section free", 16'h0, {15'h0, s[4]});
        // top page bit set: erase lands in the stalling section
        wr_reg(fsp_pkg::REG_PAGE, pg | 16'h1000);
        ee_busy <= 1'b1;
        wr_reg(fsp_pkg::REG_CMD, {13'h0, fsp_pkg::OP_ERASE});
        repeat (20) @(posedge sys_clk);
        rd_reg(fsp_pkg::REG_STATUS, s);
        check("held busy", 16'h1, {15'h0, s[0]});
        check("not started", 16'h0, {15'h0, s[4]});
        ee_busy <= 1'b0;
        wait_idle();
        check("halt page", 16'((pg | 16'h1000) << 3), u_fsp_dev_model.op_ptr);
        run_op(fsp_pkg::OP_REENABLE);
        run_op(fsp_pkg::OP_FILL);
        ee_busy <= 1'b1;
        repeat (2) @(posedge sys_clk);
        ee_busy <= 1'b0;
        rd_reg(fsp_pkg::REG_STATUS, s);
        check("lost flag", 16'h1, {15'h0, s[3]});
        check("buffer lost", 16'h0, u_fsp_dev_model.page_buf[0]);
        hang <= 1'b1;
        run_op(fsp_pkg::OP_ERASE);
        rd_reg(fsp_pkg::REG_STATUS, s);
        check("timeout", 16'h1, {15'h0, s[2]});
        hang <= 1'b0;
        repeat (30) @(posedge sys_clk);
        run_op(fsp_pkg::OP_REENABLE);
        finish_test();
    end
endmodule
